/* hw/mwe_pkg.sv */
// package of constants and state type, plus the input synchroniser
package mwe_pkg;
    // memory geometry, largest variant
    localparam int          WORD_AW    = 10;
    localparam int          BYTE_AW    = 11;
    localparam int          WORD_W     = 16;
    localparam int          MEM_WORDS  = 1024;
    localparam logic [9:0]  LAST_WORD  = 10'h3FF;
    // frame field lengths per organisation
    localparam logic [4:0]  ABITS_X16  = 5'h0A;
    localparam logic [4:0]  ABITS_X8   = 5'h0B;
    localparam logic [4:0]  DBITS_X16  = 5'h10;
    localparam logic [4:0]  DBITS_X8   = 5'h08;
    localparam logic [4:0]  OPC_LAST   = 5'h01;
    // opcodes and special sub-codes
    localparam logic [1:0]  OPC_SPEC   = 2'h0;
    localparam logic [1:0]  OPC_WRITE  = 2'h1;
    localparam logic [1:0]  OPC_READ   = 2'h2;
    localparam logic [1:0]  OPC_ERASE  = 2'h3;
    localparam logic [1:0]  SUB_WDIS   = 2'h0;
    localparam logic [1:0]  SUB_WRALL  = 2'h1;
    localparam logic [1:0]  SUB_ERALL  = 2'h2;
    localparam logic [1:0]  SUB_WEN    = 2'h3;
    // data values and masks
    localparam logic [15:0] ERASED     = 16'hFFFF;
    localparam logic [15:0] MASK_ALL   = 16'hFFFF;
    localparam logic [15:0] MASK_HI    = 16'hFF00;
    localparam logic [15:0] MASK_LO    = 16'h00FF;
    // timing: program pulse is a longest time, rounded down
    localparam int          CLK_HZ           = 20_000_000;
    localparam int          PROG_TIME_US     = 5000;
    localparam int          PROG_CYCLES_DFLT = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          PCNT_W           = 17;
    // synchroniser bit positions
    localparam int          SYNC_N  = 5;
    localparam int          IN_SK   = 0;
    localparam int          IN_CS   = 1;
    localparam int          IN_DI   = 2;
    localparam int          IN_PE   = 3;
    localparam int          IN_ORG  = 4;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_OPC  = 7'h02,
        S_ADR  = 7'h04,
        S_DAT  = 7'h08,
        S_ARM  = 7'h10,
        S_RD   = 7'h20,
        S_DONE = 7'h40
    } mwe_state_t;

    typedef struct packed {
        mwe_state_t        state;
        logic [1:0]        opc;
        logic [4:0]        cnt;
        logic [10:0]       addr;
        logic [15:0]       data;
        logic [15:0]       shreg;
        logic [15:0]       fill;
        logic [9:0]        sweep;
        logic [PCNT_W-1:0] pcnt;
        logic              sk_q;
        logic              cs_q;
        logic              wen;
        logic              busy;
        logic              sweeping;
        logic              stat_en;
        logic              rel_pend;
        logic              dout;
        logic              doe;
    } mwe_regs_t;

    localparam mwe_regs_t REGS_RST = '{state: S_IDLE, default: '0};
endpackage

// two-flop synchroniser for all pin inputs
module mwe_insync
    import mwe_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RESETN,
    // raw pins and synchronised copies
    input  wire logic [SYNC_N-1:0] PIN_IN,
    output logic      [SYNC_N-1:0] PIN_SYNC
);
    logic [SYNC_N-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            meta_reg <= '0;
            PIN_SYNC <= '0;
        end else begin
            meta_reg <= PIN_IN;
            PIN_SYNC <= meta_reg;
        end
    end
endmodule // mwe_insync

/* hw/mwe_port.sv */
// serial command port of a three-wire serial eeprom, largest variant
module mwe_port
    import mwe_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    // clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RESETN,
    // serial link pins
    input  wire logic CHIP_SELECT_IN,
    input  wire logic SERIAL_CLOCK_IN,
    input  wire logic SERIAL_DATA_IN,
    output logic      DATA_OUT,
    output logic      DATA_OUT_OE,
    // strap pins
    input  wire logic WORD_WIDTH_SELECT,
    input  wire logic PROGRAM_ENABLE_IN
);
    localparam logic [PCNT_W-1:0] PROG_LAST = PCNT_W'(PROG_CYCLES - 1);

    mwe_regs_t         r_reg;
    mwe_regs_t         r_next;
    logic [SYNC_N-1:0] syn;
    logic [15:0]       mem [MEM_WORDS];
    logic              mem_we;
    logic [9:0]        mem_idx;
    logic [15:0]       mem_wd;
    logic [15:0]       mem_mask;
    logic              sk_s, cs_s, di_s, pe_s, org_s;
    logic              sk_rise, sk_fall, cs_fall;
    logic [4:0]        abits, dbits;
    logic [10:0]       addr_sh, addr_inc;
    logic [1:0]        sub;
    logic [15:0]       nxt_word;

    mwe_insync u_sync (
        .CLK_SYS  (CLK_SYS),
        .RESETN   (RESETN),
        .PIN_IN   ({WORD_WIDTH_SELECT, PROGRAM_ENABLE_IN, SERIAL_DATA_IN, CHIP_SELECT_IN, SERIAL_CLOCK_IN}),
        .PIN_SYNC (syn)
    );

    // synchronised pins and edges
    assign sk_s    = syn[IN_SK];
    assign cs_s    = syn[IN_CS];
    assign di_s    = syn[IN_DI];
    assign pe_s    = syn[IN_PE];
    assign org_s   = syn[IN_ORG];
    assign sk_rise = sk_s & ~r_reg.sk_q;
    assign sk_fall = ~sk_s & r_reg.sk_q;
    assign cs_fall = r_reg.cs_q & ~cs_s;
    assign abits   = org_s ? ABITS_X16 : ABITS_X8;
    assign dbits   = org_s ? DBITS_X16 : DBITS_X8;
    assign addr_sh = {r_reg.addr[9:0], di_s};
    assign sub     = org_s ? addr_sh[9:8] : addr_sh[10:9];
    assign addr_inc = org_s ? {1'b0, r_reg.addr[9:0] + 10'h001} : r_reg.addr + 11'h001;

    // addressed word, left justified; in x8 odd byte is the upper half
    function automatic logic [15:0] rd_word(input logic [10:0] a);
        logic [15:0] w;
        w = org_s ? mem[a[9:0]] : mem[a[10:1]];
        if (org_s)
            return w;
        return a[0] ? {w[15:8], 8'h00} : {w[7:0], 8'h00};
    endfunction

    // next-state logic
    always_comb begin
        r_next      = r_reg;
        r_next.sk_q = sk_s;
        r_next.cs_q = cs_s;
        mem_we      = 1'b0;
        mem_idx     = r_reg.sweep;
        mem_wd      = r_reg.fill;
        mem_mask    = MASK_ALL;
        nxt_word    = rd_word(addr_inc);  // follows array and width changes
        // self-timed cycle, runs with no serial clock
        if (r_reg.busy) begin
            if (r_reg.pcnt != '0)
                r_next.pcnt = r_reg.pcnt - 1'b1;
            if (r_reg.sweeping) begin
                mem_we = 1'b1;
                if (r_reg.sweep == LAST_WORD)
                    r_next.sweeping = 1'b0;
                else
                    r_next.sweep = r_reg.sweep + 10'h001;
            end
            if (r_reg.pcnt == '0 && !r_reg.sweeping)
                r_next.busy = 1'b0;
        end
        if (!cs_s) begin
            r_next.state    = S_IDLE;
            r_next.cnt      = '0;
            r_next.rel_pend = 1'b0;
            // armed command starts on deselect
            if (cs_fall && r_reg.state == S_ARM && r_reg.wen && pe_s && !r_reg.busy) begin
                r_next.busy    = 1'b1;
                r_next.pcnt    = PROG_LAST;
                r_next.stat_en = 1'b1;
                r_next.sweep   = '0;
                mem_idx  = org_s ? r_reg.addr[9:0] : r_reg.addr[10:1];
                mem_mask = org_s ? MASK_ALL : (r_reg.addr[0] ? MASK_HI : MASK_LO);
                mem_wd   = org_s ? r_reg.data : {r_reg.data[7:0], r_reg.data[7:0]};
                case (r_reg.opc)
                    OPC_WRITE: mem_we = 1'b1;
                    OPC_ERASE: begin
                        mem_we = 1'b1;
                        mem_wd = ERASED;
                    end
                    default: begin
                        r_next.sweeping = 1'b1;
                        r_next.fill     = (r_reg.cnt == '0) ? ERASED : mem_wd;
                    end
                endcase
            end
        end else if (sk_rise) begin
            case (r_reg.state)
                S_IDLE: begin
                    if (di_s && !r_reg.busy) begin
                        r_next.rel_pend = r_reg.stat_en;
                        r_next.state    = S_OPC;
                        r_next.cnt      = '0;
                        r_next.addr     = '0;
                        r_next.data     = '0;
                    end
                end
                S_OPC: begin
                    r_next.opc = {r_reg.opc[0], di_s};
                    r_next.cnt = r_reg.cnt + 5'h01;
                    if (r_reg.cnt == OPC_LAST) begin
                        r_next.state = S_ADR;
                        r_next.cnt   = '0;
                    end
                end
                S_ADR: begin
                    r_next.addr = addr_sh;
                    r_next.cnt  = r_reg.cnt + 5'h01;
                    if (r_reg.cnt == abits - 5'h01) begin
                        r_next.cnt   = '0;
                        r_next.state = S_ARM;
                        case (r_reg.opc)
                            OPC_READ: begin
                                r_next.state = S_RD;
                                r_next.shreg = rd_word(addr_sh);
                                r_next.dout  = 1'b0;
                            end
                            OPC_WRITE: r_next.state = S_DAT;
                            OPC_ERASE: r_next.state = S_ARM;
                            default: begin
                                // cnt marks the fill source: zero for erase-all
                                case (sub)
                                    SUB_WEN: begin
                                        r_next.wen   = 1'b1;
                                        r_next.state = S_DONE;
                                    end
                                    SUB_WDIS: begin
                                        r_next.wen   = 1'b0;
                                        r_next.state = S_DONE;
                                    end
                                    SUB_WRALL: begin
                                        r_next.state = S_DAT;
                                        r_next.cnt   = '0;
                                    end
                                    default: r_next.state = S_ARM;
                                endcase
                            end
                        endcase
                    end
                end
                S_DAT: begin
                    r_next.data = {r_reg.data[14:0], di_s};
                    r_next.cnt  = r_reg.cnt + 5'h01;
                    if (r_reg.cnt == dbits - 5'h01)
                        r_next.state = S_ARM;
                end
                S_RD: begin
                    if (r_reg.cnt == dbits) begin
                        // next word follows with no dummy bit
                        r_next.addr  = addr_inc;
                        r_next.dout  = nxt_word[15];
                        r_next.shreg = {nxt_word[14:0], 1'b0};
                        r_next.cnt   = 5'h01;
                    end else begin
                        r_next.dout  = r_reg.shreg[15];
                        r_next.shreg = {r_reg.shreg[14:0], 1'b0};
                        r_next.cnt   = r_reg.cnt + 5'h01;
                    end
                end
                default: r_next.state = r_reg.state;
            endcase
        end
        // status release on the falling serial clock edge
        if (cs_s && sk_fall && r_reg.rel_pend) begin
            r_next.stat_en  = 1'b0;
            r_next.rel_pend = 1'b0;
        end
        // erase-all fills ones, write-all fills the data field
        if (cs_s && sk_rise && r_reg.state == S_DAT)
            r_next.cnt = (r_reg.cnt == dbits - 5'h01) ? 5'h01 : r_next.cnt;
        r_next.doe = cs_s && (r_next.state == S_RD || r_next.stat_en);
        if (r_next.state != S_RD)
            r_next.dout = ~r_next.busy;
    end

    // state register
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN)
            r_reg <= REGS_RST;
        else
            r_reg <= r_next;
    end

    // array write with byte mask
    always_ff @(posedge CLK_SYS) begin
        if (mem_we)
            mem[mem_idx] <= (mem[mem_idx] & ~mem_mask) | (mem_wd & mem_mask);
    end

    assign DATA_OUT    = r_reg.dout;
    assign DATA_OUT_OE = r_reg.doe;

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    sequence s_armed_fall;
        cs_fall && r_reg.state == S_ARM && !r_reg.busy;
    endsequence

    property p_hiz_deselect;
        !cs_s |=> !DATA_OUT_OE;
    endproperty
    a_hiz_deselect: assert property (p_hiz_deselect) else $error("output driven while deselected");

    property p_busy_low;
        cs_s && r_reg.stat_en && !r_reg.rel_pend && r_reg.state != S_RD && r_reg.busy && r_reg.pcnt > 1
            |=> DATA_OUT_OE && !DATA_OUT;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("status not low while busy");

    property p_ready_high;
        cs_s && r_reg.stat_en && !sk_fall && r_reg.state == S_IDLE && !r_reg.busy |=> DATA_OUT_OE && DATA_OUT;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("status not high when ready");

    property p_release_fall;
        cs_s && $fell(r_reg.stat_en) |-> $past(sk_fall) && $past(r_reg.rel_pend);
    endproperty
    a_release_fall: assert property (p_release_fall) else $error("status released off falling edge");

    property p_reject_disabled;
        s_armed_fall and !r_reg.wen |=> !r_reg.busy;
    endproperty
    a_reject_disabled: assert property (p_reject_disabled) else $error("write accepted while disabled");

    property p_pe_gate;
        s_armed_fall and !pe_s |=> !r_reg.busy;
    endproperty
    a_pe_gate: assert property (p_pe_gate) else $error("write accepted with program enable low");

    property p_start_busy;
        s_armed_fall and r_reg.wen && pe_s |=> r_reg.busy && r_reg.pcnt == PROG_LAST ##1 r_reg.busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("program cycle not started on deselect");

    property p_busy_end;
        r_reg.busy && r_reg.pcnt == '0 && !r_reg.sweeping |=> !r_reg.busy ##1 !r_reg.busy;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy beyond program time");

    property p_dummy_zero;
        cs_s && $rose(r_reg.state == S_RD) |=> DATA_OUT_OE && !DATA_OUT;
    endproperty
    a_dummy_zero: assert property (p_dummy_zero) else $error("no dummy zero before read data");

    property p_start_bit;
        cs_s && sk_rise && r_reg.state == S_IDLE && di_s && !r_reg.busy |=> r_reg.state == S_OPC;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not taken");
endmodule // mwe_port

/* sim/mwe_ctl_model.sv */
// controller model: drives command frames and samples the data output
module mwe_ctl_model
    import mwe_pkg::*;
(
    // clock
    input  wire logic       CLK_SYS,
    // serial link pins
    output logic            cs,
    output logic            sk,
    output logic            di,
    input  wire logic       DATA_OUT,
    input  wire logic       DATA_OUT_OE,
    // sampled {enable, line} to the bench
    output logic            smp_vld,
    output logic      [1:0] smp_val
);
    timeunit 1ns;
    timeprecision 1ps;
    logic do_last = 1'b0;
    logic do_wire;

    // released line shows the inverse of the last driven level
    always @(posedge CLK_SYS) if (DATA_OUT_OE) do_last <= DATA_OUT;
    assign do_wire = DATA_OUT_OE ? DATA_OUT : ~do_last;

    // link idles deselected with clock low
    initial begin
        cs = 1'b0;
        sk = 1'b0;
        di = 1'b0;
        smp_vld = 1'b0;
        smp_val = 2'h0;
    end

    // one-cycle sample strobe
    task automatic smp_now();
        smp_val <= DATA_OUT_OE ? {1'b1, do_wire} : 2'h0;
        smp_vld <= 1'b1;
        @(posedge CLK_SYS);
        smp_vld <= 1'b0;
    endtask

    // one bit: data set at clock fall, output sampled just before the rise
    task automatic sbit(input logic d, input logic smp);
        sk <= 1'b0;
        di <= d;
        repeat (3) @(posedge CLK_SYS);
        if (smp) smp_now();
        else @(posedge CLK_SYS);
        sk <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
    endtask

    // whole frame msb first, then nrd sampled bits, then minimum deselect
    task automatic frame(input logic [31:0] v, input int n, input int nrd);
        cs <= 1'b1;
        @(posedge CLK_SYS);
        for (int i = n - 1; i >= 0; i--) sbit(v[i], 1'b0);
        for (int i = 0; i < nrd; i++) sbit(1'b0, 1'b1);
        sk <= 1'b0;
        cs <= 1'b0;
        repeat (24) @(posedge CLK_SYS);
    endtask

    // status poll, optionally released by shifting a one
    task automatic poll(input logic rel);
        cs <= 1'b1;
        repeat (8) @(posedge CLK_SYS);
        smp_now();
        if (rel) begin
            sbit(1'b1, 1'b0);
            smp_now();
            sk <= 1'b0;
            repeat (8) @(posedge CLK_SYS);
            smp_now();
        end
        sk <= 1'b0;
        cs <= 1'b0;
        repeat (24) @(posedge CLK_SYS);
    endtask
endmodule // mwe_ctl_model

/* sim/tb.sv */
// testbench: command frames through the controller model, queued output checks
module tb
    import mwe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG     = 50;
    localparam int BUSY_W   = PROG + 1;
    localparam int BUSY_ALL = 1025 + 1;
    localparam int PWRUP    = 20000;

    logic       clk_sys;
    logic       resetn;
    logic       wws;
    logic       pe;
    logic       cs;
    logic       sk;
    logic       di;
    logic       dout;
    logic       doe;
    logic       smp_vld;
    logic [1:0] smp_val;
    logic [1:0] exp_q[$];
    logic [15:0] d_rand;
    logic [7:0]  b_rand;
    int         seed = 18;
    int         num_errors = 0;
    int         compares = 0;

    mwe_port #(.PROG_CYCLES(PROG)) u_dut (
        .CLK_SYS(clk_sys), .RESETN(resetn), .CHIP_SELECT_IN(cs), .SERIAL_CLOCK_IN(sk),
        .SERIAL_DATA_IN(di), .DATA_OUT(dout), .DATA_OUT_OE(doe),
        .WORD_WIDTH_SELECT(wws), .PROGRAM_ENABLE_IN(pe));

    mwe_ctl_model u_ctl (
        .CLK_SYS(clk_sys), .cs(cs), .sk(sk), .di(di), .DATA_OUT(dout),
        .DATA_OUT_OE(doe), .smp_vld(smp_vld), .smp_val(smp_val));

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // x16 frame with nd data bits
    task automatic cmd16(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d, input int nd);
        u_ctl.frame({1'b1, op, a, d} >> (16 - nd), 13 + nd, 0);
    endtask

    // x16 read of words, dummy zero first
    task automatic rd16(input logic [9:0] a, input logic [15:0] w0, input logic [15:0] w1, input int nw);
        exp_q.push_back(2'h2);
        for (int i = 15; i >= 0; i--) exp_q.push_back({1'b1, w0[i]});
        for (int i = 15; i >= 0 && nw > 1; i--) exp_q.push_back({1'b1, w1[i]});
        u_ctl.frame({1'b1, OPC_READ, a}, 13, 1 + 16 * nw);
    endtask

    // busy right after start, ready after the bounded cycle, then release
    task automatic prog_wait(input int n);
        exp_q.push_back(2'h2);
        u_ctl.poll(1'b0);
        repeat (n + 10) @(posedge clk_sys);
        exp_q.push_back(2'h3);
        exp_q.push_back(2'h3);
        exp_q.push_back(2'h0);
        u_ctl.poll(1'b1);
    endtask

    // monitor: oldest expectation against each sample
    always @(posedge clk_sys) begin
        if (smp_vld) check(smp_val, exp_q.size() != 0 ? exp_q.pop_front() : 2'bxx);
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        test_done();
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        wws = 1'b1;
        pe = 1'b1;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (PWRUP) @(posedge clk_sys);
        exp_q.push_back(2'h0);
        u_ctl.smp_now();
        d_rand = 16'($random(seed));
        b_rand = 8'($random(seed));
        pe <= 1'($random(seed));
        // writes dropped while disabled and with program enable low
        cmd16(OPC_WRITE, 10'h005, d_rand, 16);
        exp_q.push_back(2'h0);
        u_ctl.poll(1'b0);
        pe <= 1'b0;
        cmd16(OPC_SPEC, 10'h300, 16'h0000, 0);
        cmd16(OPC_SPEC, 10'h200, 16'h0000, 0);
        exp_q.push_back(2'h0);
        u_ctl.poll(1'b0);
        $display("test refused writes done");
        // erase all, then write the last word and read across the wrap
        pe <= 1'b1;
        cmd16(OPC_SPEC, 10'h200, 16'h0000, 0);
        prog_wait(BUSY_ALL);
        cmd16(OPC_WRITE, 10'h3FF, d_rand, 16);
        prog_wait(BUSY_W);
        pe <= 1'($random(seed));
        rd16(10'h3FF, d_rand, ERASED, 2);
        $display("test erase write wrap done");
        // byte organisation: upper byte of word 0
        wws <= 1'b0;
        pe <= 1'b1;
        u_ctl.frame({1'b1, OPC_WRITE, 11'h001, b_rand}, 22, 0);
        prog_wait(BUSY_W);
        exp_q.push_back(2'h2);
        for (int i = 7; i >= 0; i--) exp_q.push_back({1'b1, b_rand[i]});
        u_ctl.frame({1'b1, OPC_READ, 11'h001}, 14, 9);
        wws <= 1'b1;
        rd16(10'h000, {b_rand, 8'hFF}, 16'h0000, 1);
        $display("test byte write done");
        // single erase, write all, then disable
        cmd16(OPC_ERASE, 10'h3FF, 16'h0000, 0);
        prog_wait(BUSY_W);
        rd16(10'h3FF, ERASED, 16'h0000, 1);
        cmd16(OPC_SPEC, 10'h100, d_rand, 16);
        prog_wait(BUSY_ALL);
        rd16(10'h005, d_rand, 16'h0000, 1);
        pe <= 1'($random(seed));
        cmd16(OPC_SPEC, 10'h000, 16'h0000, 0);
        cmd16(OPC_WRITE, 10'h005, ~d_rand, 16);
        exp_q.push_back(2'h0);
        u_ctl.poll(1'b0);
        rd16(10'h005, d_rand, 16'h0000, 1);
        $display("test erase write-all disable done");
        repeat (4) @(posedge clk_sys);
        if (exp_q.size() != 0) num_errors++;
        test_done();
    end
endmodule // tb
